// file: timing_now_pkg.sv
// What this block does
// - Values readable always, software writes ignored, updated only in setup/power-saving/halted.
// - Power-down entry blocks later rank commands for the 8-bit entry delay.
// - Power-down exit applies non-DLL delay, and DLL delay from bits 23:16.
// - Self-refresh entry blocks later rank commands for the 8-bit entry delay.
// - Self-refresh exit applies 10-bit non-DLL delay and 11-bit DLL delay.
// - Clock stop waits the 5-bit delay after entry before disabling the clock.
// - Clock restart waits the 5-bit delay after enabling before leaving self-refresh.
// - Deep power-down exit delay is a 12-bit field in bits 11:0.
// - After deep power-down exit, rank commands wait the programmed exit delay.
// - Command-address latency, bits 11:8, is accounted for in read-enable and read-valid deadline timing.
// - Command/address bus driven the programmed clocks after chip select.
// - Command complete the programmed cycles after its chip select.
// - Parity input driven the programmed clocks after chip select.
// - ZQ short calibration blocks dependent commands for the 10-bit delay.
// - Read enable asserted the programmed time after a read starts.
// - Read-data chip select asserted the 5-bit latency after read chip select.
// - Read-enable alignment field is stored only, no effect on behaviour.
// - Read-data valid is expected no later than the maximum after read enable.
// - Maximum PHY read latency is a 6-bit field in bits 5:0.
package timing_now_pkg;
  localparam logic [15:0] OFS_XMPD    = 16'h1254;
  localparam logic [15:0] OFS_EP      = 16'h1258;
  localparam logic [15:0] OFS_XP      = 16'h125C;
  localparam logic [15:0] OFS_ESR     = 16'h1260;
  localparam logic [15:0] OFS_XSR     = 16'h1264;
  localparam logic [15:0] OFS_ESRCK   = 16'h1268;
  localparam logic [15:0] OFS_CKXSR   = 16'h126C;
  localparam logic [15:0] OFS_CMD     = 16'h1270;
  localparam logic [15:0] OFS_PARITY  = 16'h1274;
  localparam logic [15:0] OFS_ZQCS    = 16'h1278;
  localparam logic [15:0] OFS_RDEN    = 16'h1300;
  localparam logic [15:0] OFS_PHYRD   = 16'h1304;

  localparam logic [31:0] RST_XMPD    = 32'h000003FF;
  localparam logic [31:0] RST_EP      = 32'h00000002;
  localparam logic [31:0] RST_XP      = 32'h00060002;
  localparam logic [31:0] RST_ESR     = 32'h0000000E;
  localparam logic [31:0] RST_XSR     = 32'h05120100;
  localparam logic [31:0] RST_ESRCK   = 32'h00000005;
  localparam logic [31:0] RST_CKXSR   = 32'h00000001;
  localparam logic [31:0] RST_CMD     = 32'h00000000;
  localparam logic [31:0] RST_PARITY  = 32'h00000900;
  localparam logic [31:0] RST_ZQCS    = 32'h00000040;
  localparam logic [31:0] RST_RDEN    = 32'h00000001;
  localparam logic [31:0] RST_PHYRD   = 32'h00000000;

  // Upper and middle field lsbs in split registers
  localparam int HI_LSB  = 16;
  localparam int MID_LSB = 8;

  typedef enum logic [2:0] {
    ST_RESET     = 3'b000,
    ST_CONFIG    = 3'b001,
    ST_READY     = 3'b010,
    ST_LOW_POWER = 3'b011,
    halted_state = 3'b100
  } ctrl_state_t;

  typedef enum logic [2:0] {
    EV_PD_ENTRY  = 3'b000,
    EV_PD_EXIT   = 3'b001,
    EV_SR_ENTRY  = 3'b010,
    EV_SR_EXIT   = 3'b011,
    EV_MPD_EXIT  = 3'b100,
    EV_ZQ_SHORT  = 3'b101,
    EV_CLK_STOP  = 3'b110,
    EV_CLK_START = 3'b111
  } timing_event_t;

  typedef struct packed {
    logic [11:0] mpd_exit;
    logic [7:0]  pd_entry_cycles;
    logic [7:0]  pd_exit_nodll_cycles;
    logic [7:0]  pd_exit_dll;
    logic [7:0]  sr_entry;
    logic [9:0]  sr_exit_nodll;
    logic [10:0] sr_exit_dll;
    logic [4:0]  clk_stop;
    logic [4:0]  clk_restart;
    logic [3:0]  ca_lat;
    logic [3:0]  cmd_lat;
    logic [5:0]  completion;
    logic [1:0]  parity_lat;
    logic [9:0]  zq_short;
    logic [5:0]  rd_en_lat;
    logic [5:0]  rd_en_diff;
    logic [4:0]  rd_cs_lat;
    logic [5:0]  phy_rd_lat_max;
  } timing_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : timing_now_pkg

// file: timing_now.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module timing_now
  import timing_now_pkg::*;
#(
  parameter int N_RANKS    = 4,
  parameter int HIST_DEPTH = 128
)(
  input  wire logic                 clk_sys_i,
  input  wire logic                 srst_i,
  input  wire apb_req_t             apb_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire ctrl_state_t          ctrl_state_i,
  input  wire logic                 upd_valid_i,
  input  wire logic [15:0]          upd_addr_i,
  input  wire logic [31:0]          upd_data_i,
  input  wire logic                 evt_valid_i,
  input  wire timing_event_t        evt_kind_i,
  input  wire logic [$clog2(N_RANKS > 1 ? N_RANKS : 2)-1:0] evt_rank_i,
  input  wire logic                 cs_valid_i,
  input  wire logic                 cs_read_i,
  output logic [N_RANKS-1:0]        rank_nodll_ready_o,
  output logic [N_RANKS-1:0]        rank_dll_ready_o,
  output logic [N_RANKS-1:0]        rank_clk_ready_o,
  output logic                      cmd_drive_o,
  output logic                      parity_drive_o,
  output logic                      cmd_done_o,
  output logic                      rd_en_o,
  output logic                      rd_cs_o,
  output logic                      rd_valid_deadline_o,
  output timing_t                   active_o
);
  localparam int RW = (N_RANKS > 1) ? $clog2(N_RANKS) : 1;
  // Largest supported field values that feed a history tap
  localparam int RD_EN_MAX  = 40;
  localparam int CA_LAT_MAX = 10;
  localparam int PHY_RD_MAX = 62;
  // Longest tap: read enable plus address latency plus read latency
  localparam int MAX_TAP    = RD_EN_MAX + CA_LAT_MAX + PHY_RD_MAX;

  if (N_RANKS < 1)
  begin : g_bad_ranks
    $error("timing_now: N_RANKS must be at least 1");
  end

  // A shorter history cannot serve the longest supported read delay
  if (HIST_DEPTH < MAX_TAP)
  begin : g_bad_depth
    $error("timing_now: HIST_DEPTH must cover the longest read tap");
  end

  timing_t     act_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        rd_hit;
  logic [31:0] rd_word;

  function automatic logic [31:0] reg_word(input timing_t t, input logic [15:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    if (a == OFS_XMPD)
      w[11:0] = t.mpd_exit;
    else if (a == OFS_EP)
      w[7:0] = t.pd_entry_cycles;
    else if (a == OFS_XP)
    begin
      w[7:0] = t.pd_exit_nodll_cycles;
      w[HI_LSB +: 8] = t.pd_exit_dll;
    end
    else if (a == OFS_ESR)
      w[7:0] = t.sr_entry;
    else if (a == OFS_XSR)
    begin
      w[9:0] = t.sr_exit_nodll;
      w[HI_LSB +: 11] = t.sr_exit_dll;
    end
    else if (a == OFS_ESRCK)
      w[4:0] = t.clk_stop;
    else if (a == OFS_CKXSR)
      w[4:0] = t.clk_restart;
    else if (a == OFS_CMD)
    begin
      w[3:0] = t.cmd_lat;
      w[MID_LSB +: 4] = t.ca_lat;
    end
    else if (a == OFS_PARITY)
    begin
      w[1:0] = t.parity_lat;
      w[MID_LSB +: 6] = t.completion;
    end
    else if (a == OFS_ZQCS)
      w[9:0] = t.zq_short;
    else if (a == OFS_RDEN)
    begin
      w[5:0] = t.rd_en_lat;
      w[MID_LSB +: 6] = t.rd_en_diff;
      w[HI_LSB +: 5] = t.rd_cs_lat;
    end
    else if (a == OFS_PHYRD)
      w[5:0] = t.phy_rd_lat_max;
    return w;
  endfunction : reg_word

  function automatic logic is_mapped(input logic [15:0] a);
    return (a == OFS_XMPD) || (a == OFS_EP) || (a == OFS_XP) || (a == OFS_ESR) ||
           (a == OFS_XSR) || (a == OFS_ESRCK) || (a == OFS_CKXSR) || (a == OFS_CMD) ||
           (a == OFS_PARITY) || (a == OFS_ZQCS) || (a == OFS_RDEN) || (a == OFS_PHYRD);
  endfunction : is_mapped

  function automatic timing_t load_word(input timing_t t, input logic [15:0] a,
                                        input logic [31:0] d);
    timing_t n;
    n = t;
    if (a == OFS_XMPD)
      n.mpd_exit = d[11:0];
    else if (a == OFS_EP)
      n.pd_entry_cycles = d[7:0];
    else if (a == OFS_XP)
    begin
      n.pd_exit_nodll_cycles = d[7:0];
      n.pd_exit_dll = d[HI_LSB +: 8];
    end
    else if (a == OFS_ESR)
      n.sr_entry = d[7:0];
    else if (a == OFS_XSR)
    begin
      n.sr_exit_nodll = d[9:0];
      n.sr_exit_dll = d[HI_LSB +: 11];
    end
    else if (a == OFS_ESRCK)
      n.clk_stop = d[4:0];
    else if (a == OFS_CKXSR)
      n.clk_restart = d[4:0];
    else if (a == OFS_CMD)
    begin
      n.cmd_lat = d[3:0];
      n.ca_lat = d[MID_LSB +: 4];
    end
    else if (a == OFS_PARITY)
    begin
      n.parity_lat = d[1:0];
      n.completion = d[MID_LSB +: 6];
    end
    else if (a == OFS_ZQCS)
      n.zq_short = d[9:0];
    else if (a == OFS_RDEN)
    begin
      n.rd_en_lat = d[5:0];
      n.rd_en_diff = d[MID_LSB +: 6];
      n.rd_cs_lat = d[HI_LSB +: 5];
    end
    else if (a == OFS_PHYRD)
      n.phy_rd_lat_max = d[5:0];
    return n;
  endfunction : load_word

  function automatic timing_t reset_set();
    timing_t n;
    n = '0;
    n = load_word(n, OFS_XMPD, RST_XMPD);
    n = load_word(n, OFS_EP, RST_EP);
    n = load_word(n, OFS_XP, RST_XP);
    n = load_word(n, OFS_ESR, RST_ESR);
    n = load_word(n, OFS_XSR, RST_XSR);
    n = load_word(n, OFS_ESRCK, RST_ESRCK);
    n = load_word(n, OFS_CKXSR, RST_CKXSR);
    n = load_word(n, OFS_CMD, RST_CMD);
    n = load_word(n, OFS_PARITY, RST_PARITY);
    n = load_word(n, OFS_ZQCS, RST_ZQCS);
    n = load_word(n, OFS_RDEN, RST_RDEN);
    n = load_word(n, OFS_PHYRD, RST_PHYRD);
    return n;
  endfunction : reset_set

  localparam timing_t ACT_RESET = reset_set();

  // Active set: only the controller's update path may change it
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      act_reg <= ACT_RESET;
    else if (upd_valid_i && (ctrl_state_i == ST_CONFIG || ctrl_state_i == ST_LOW_POWER ||
                             ctrl_state_i == halted_state))
      act_reg <= load_word(act_reg, upd_addr_i, upd_data_i);
  end

  assign active_o = act_reg;

  // APB: data latched in setup so the access phase needs no wait state
  assign rd_hit  = is_mapped(apb_i.paddr[15:0]) && (apb_i.paddr[31:16] == 16'h0000);
  assign rd_word = reg_word(act_reg, apb_i.paddr[15:0]);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (apb_i.psel && !apb_i.penable)
    begin
      // Writes to mapped addresses complete cleanly but store nothing
      prdata_reg  <= (rd_hit && !apb_i.pwrite) ? rd_word : 32'h00000000;
      pslverr_reg <= !rd_hit;
    end
  end

  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg && apb_i.psel && apb_i.penable;

  // Per-rank timers; a new trigger never shortens a running non-DLL or DLL wait, but reloads the clock wait
  function automatic logic [11:0] max12(input logic [11:0] a, input logic [11:0] b);
    return (a > b) ? a : b;
  endfunction : max12

  for (genvar r = 0; r < N_RANKS; r++)
  begin : g_rank
    logic [11:0] nodll_reg;
    logic [11:0] dll_reg;
    logic [4:0]  clk_reg;
    logic [11:0] nodll_ld;
    logic [11:0] dll_ld;
    logic        hit;
    logic [11:0] nodll_dec;
    logic [11:0] dll_dec;

    assign hit = evt_valid_i && (evt_rank_i == RW'(r));

    always_comb
    begin
      nodll_ld = 12'h000;
      dll_ld   = 12'h000;
      case (evt_kind_i)
        EV_PD_ENTRY:
        begin
          nodll_ld = {4'h0, act_reg.pd_entry_cycles};
          dll_ld   = {4'h0, act_reg.pd_entry_cycles};
        end
        EV_PD_EXIT:
        begin
          nodll_ld = {4'h0, act_reg.pd_exit_nodll_cycles};
          dll_ld   = {4'h0, act_reg.pd_exit_dll};
        end
        EV_SR_ENTRY:
        begin
          nodll_ld = {4'h0, act_reg.sr_entry};
          dll_ld   = {4'h0, act_reg.sr_entry};
        end
        EV_SR_EXIT:
        begin
          nodll_ld = {2'b00, act_reg.sr_exit_nodll};
          dll_ld   = {1'b0, act_reg.sr_exit_dll};
        end
        EV_MPD_EXIT:
        begin
          nodll_ld = act_reg.mpd_exit;
          dll_ld   = act_reg.mpd_exit;
        end
        EV_ZQ_SHORT:
        begin
          nodll_ld = {2'b00, act_reg.zq_short};
          dll_ld   = {2'b00, act_reg.zq_short};
        end
        default:
        begin
          nodll_ld = 12'h000;
          dll_ld   = 12'h000;
        end
      endcase
    end

    // Count on through a load cycle, so a repeated trigger adds no extra cycle
    assign nodll_dec = (nodll_reg != 12'h000) ? nodll_reg - 12'h001 : 12'h000;
    assign dll_dec   = (dll_reg != 12'h000) ? dll_reg - 12'h001 : 12'h000;

    always_ff @(posedge clk_sys_i)
    begin
      if (srst_i)
        nodll_reg <= 12'h000;
      else if (hit)
        nodll_reg <= max12(nodll_ld, nodll_dec);
      else
        nodll_reg <= nodll_dec;
    end

    always_ff @(posedge clk_sys_i)
    begin
      if (srst_i)
        dll_reg <= 12'h000;
      else if (hit)
        dll_reg <= max12(dll_ld, dll_dec);
      else
        dll_reg <= dll_dec;
    end

    always_ff @(posedge clk_sys_i)
    begin
      if (srst_i)
        clk_reg <= 5'h00;
      else if (hit && evt_kind_i == EV_CLK_STOP)
        clk_reg <= act_reg.clk_stop;
      else if (hit && evt_kind_i == EV_CLK_START)
        clk_reg <= act_reg.clk_restart;
      else if (clk_reg != 5'h00)
        clk_reg <= clk_reg - 5'h01;
    end

    assign rank_nodll_ready_o[r] = (nodll_reg == 12'h000);
    assign rank_dll_ready_o[r]   = (dll_reg == 12'h000) && (nodll_reg == 12'h000);
    assign rank_clk_ready_o[r]   = (clk_reg == 5'h00);
  end

  // Chip-select history: tap d is the chip select d cycles ago.
  // DFI and controller clocks are taken as 1:1.
  logic [HIST_DEPTH-1:0] cs_hist_reg;
  logic [HIST_DEPTH-1:0] rd_hist_reg;
  logic [HIST_DEPTH:0]   cs_tap;
  logic [HIST_DEPTH:0]   rd_tap;
  logic [7:0]            rd_en_dly;
  logic [7:0]            rd_dead_dly;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cs_hist_reg <= '0;
      rd_hist_reg <= '0;
    end
    else
    begin
      cs_hist_reg <= cs_tap[HIST_DEPTH-1:0];
      rd_hist_reg <= rd_tap[HIST_DEPTH-1:0];
    end
  end

  assign cs_tap = {cs_hist_reg, cs_valid_i};
  assign rd_tap = {rd_hist_reg, cs_valid_i && cs_read_i};

  // Command-address latency pushes read data timing back
  assign rd_en_dly   = 8'(act_reg.rd_en_lat) + 8'(act_reg.ca_lat);
  assign rd_dead_dly = rd_en_dly + 8'(act_reg.phy_rd_lat_max);

  // rd_en_diff is deliberately unused here
  assign cmd_drive_o         = cs_tap[act_reg.cmd_lat];
  assign parity_drive_o      = cs_tap[act_reg.parity_lat];
  assign cmd_done_o          = cs_tap[act_reg.completion];
  // Settings beyond the history give no pulse rather than an unknown one
  assign rd_en_o             = (int'(rd_en_dly) <= HIST_DEPTH) && rd_tap[rd_en_dly];
  assign rd_cs_o             = rd_tap[act_reg.rd_cs_lat];
  assign rd_valid_deadline_o = (int'(rd_dead_dly) <= HIST_DEPTH) && rd_tap[rd_dead_dly];
endmodule : timing_now
`default_nettype wire

// file: timing_now_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module timing_now_monitor
  import timing_now_pkg::*;
#(
  parameter int N_RANKS = 4,
  parameter int RW      = $clog2(N_RANKS)
)(
  input wire logic               clk_sys_i,
  input wire logic               srst_i,
  input wire apb_req_t           apb_i,
  input wire logic               pready_o,
  input wire logic               pslverr_o,
  input wire ctrl_state_t        ctrl_state_i,
  input wire logic               upd_valid_i,
  input wire logic               evt_valid_i,
  input wire timing_event_t      evt_kind_i,
  input wire logic [RW-1:0]      evt_rank_i,
  input wire logic               cs_valid_i,
  input wire logic               cs_read_i,
  input wire logic [N_RANKS-1:0] rank_nodll_ready_o,
  input wire logic [N_RANKS-1:0] rank_dll_ready_o,
  input wire logic               cmd_drive_o,
  input wire logic               cmd_done_o,
  input wire logic               rd_en_o,
  input wire logic               rd_valid_deadline_o,
  input wire timing_t            active_o
);
  logic st_ok;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  assign st_ok = ctrl_state_i inside {ST_CONFIG, ST_LOW_POWER, halted_state};
  chk_pready_high: assert property (pready_o)
    else $error("pready low");
  chk_unmapped_err: assert property (apb_i.psel && apb_i.penable && apb_i.paddr[31:16] != 16'h0 |-> pslverr_o)
    else $error("no error on unmapped read");
  chk_frozen_values: assert property ($changed(active_o) |-> $past(upd_valid_i) && $past(st_ok))
    else $error("active value changed outside update");
  chk_cmd_now: assert property (cs_valid_i && active_o.cmd_lat == 4'h0 |-> cmd_drive_o)
    else $error("command bus late");
  chk_done_nine: assert property (cs_valid_i && active_o.completion == 6'h09 |-> ##9 cmd_done_o)
    else $error("completion not at nine");
  chk_rd_en_next: assert property (cs_valid_i && cs_read_i && active_o.rd_en_lat == 6'h01
    && active_o.ca_lat == 4'h0 |=> rd_en_o)
    else $error("read enable not next cycle");
  chk_entry_blocks: assert property (evt_valid_i && evt_kind_i == EV_PD_ENTRY
    |=> !rank_nodll_ready_o[$past(evt_rank_i)])
    else $error("rank not held after entry");
  chk_sr_exit_dll: assert property (evt_valid_i && evt_kind_i == EV_SR_EXIT
    |=> !rank_dll_ready_o[$past(evt_rank_i)])
    else $error("dll ready right after self-refresh exit");
  chk_deadline_zero: assert property (rd_en_o && active_o.phy_rd_lat_max == 6'h00 |-> rd_valid_deadline_o)
    else $error("deadline not with read enable");
endmodule : timing_now_monitor
`default_nettype wire

// file: timing_now_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module timing_now_phy_model (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       rd_en_i,
  input  wire logic       deadline_i,
  input  wire logic       slow_i,
  input  wire logic [5:0] lat_i,
  output logic            valid_o,
  output logic            late_o
);
  logic       pend_reg;
  logic [5:0] wait_reg;
  // Slow mode answers on the last legal cycle
  assign valid_o = pend_reg && (!slow_i || wait_reg == lat_i - 6'h1);
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i || rd_en_i || valid_o)
      wait_reg <= 6'h0;
    else if (pend_reg)
      wait_reg <= wait_reg + 6'h1;
    pend_reg <= !srst_i && (rd_en_i || (pend_reg && !valid_o));
    late_o   <= !srst_i && (late_o || (deadline_i && pend_reg && !valid_o));
  end
endmodule : timing_now_phy_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import timing_now_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          srst_i    = 1'b1;
  apb_req_t      apb       = '0;
  ctrl_state_t   st        = ST_CONFIG;
  logic          upd_v     = 1'b0;
  logic [15:0]   upd_a     = 16'h0;
  logic [31:0]   upd_d     = 32'h0;
  logic          evt_v     = 1'b0;
  timing_event_t evt_k     = EV_PD_ENTRY;
  logic [1:0]    evt_r     = 2'h0;
  logic          cs_v      = 1'b0;
  logic          cs_rd     = 1'b0;
  logic          slow      = 1'b0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [3:0]    nodll;
  logic [3:0]    dll;
  logic [3:0]    clkr;
  wire logic [5:0] pls;
  logic          late;
  timing_t       act;
  int            error_cnt = 0;
  int            checked   = 0;
  localparam logic [15:0] OFS [12] = '{OFS_XMPD, OFS_EP, OFS_XP, OFS_ESR, OFS_XSR, OFS_ESRCK,
    OFS_CKXSR, OFS_CMD, OFS_PARITY, OFS_ZQCS, OFS_RDEN, OFS_PHYRD};
  localparam logic [31:0] RST [12] = '{RST_XMPD, RST_EP, RST_XP, RST_ESR, RST_XSR, RST_ESRCK,
    RST_CKXSR, RST_CMD, RST_PARITY, RST_ZQCS, RST_RDEN, RST_PHYRD};
  always #5 clk_sys_i = ~clk_sys_i;
  timing_now #(.N_RANKS(4)) timing_now_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ctrl_state_i(st), .upd_valid_i(upd_v),
    .upd_addr_i(upd_a), .upd_data_i(upd_d), .evt_valid_i(evt_v), .evt_kind_i(evt_k), .evt_rank_i(evt_r),
    .cs_valid_i(cs_v), .cs_read_i(cs_rd), .rank_nodll_ready_o(nodll), .rank_dll_ready_o(dll),
    .rank_clk_ready_o(clkr), .cmd_drive_o(pls[0]), .parity_drive_o(pls[1]), .cmd_done_o(pls[2]),
    .rd_en_o(pls[3]), .rd_cs_o(pls[4]), .rd_valid_deadline_o(pls[5]), .active_o(act));
  timing_now_phy_model timing_now_phy_model_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .rd_en_i(pls[3]),
    .deadline_i(pls[5]), .slow_i(slow), .lat_i(act.phy_rd_lat_max), .valid_o(), .late_o(late));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb_xfer(input logic [31:0] a, input logic w, output logic [31:0] d, output logic e);
    @(posedge clk_sys_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: 32'hFFFFFFFF};
    @(posedge clk_sys_i);
    apb.penable <= 1'b1;
    // Only the watchdog ends a stuck access phase
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    apb <= '0;
  endtask : apb_xfer
  task automatic upd(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {upd_v, upd_a, upd_d} <= {1'b1, a, d};
    @(posedge clk_sys_i);
    upd_v <= 1'b0;
  endtask : upd
  // Counts cycles the chosen ready bit stays low after the event
  task automatic measure(input timing_event_t k, input logic [1:0] r, input int sel, input int exp);
    int n;
    logic [3:0] v;
    @(posedge clk_sys_i);
    {evt_v, evt_k, evt_r} <= {1'b1, k, r};
    @(posedge clk_sys_i);
    evt_v <= 1'b0;
    n = 0;
    #1;
    check(32'(dll[r^2'h1]), 32'h1);
    forever
    begin
      v = (sel == 0) ? nodll : (sel == 1) ? dll : clkr;
      if (v[r] !== 1'b0 || n > 3000)
        break;
      n++;
      @(posedge clk_sys_i);
      #1;
    end
    check(32'(n), 32'(exp));
  endtask : measure
  task automatic cs_meas(input logic rd, input int exp [6]);
    int off [6];
    off = '{default: 99};
    @(posedge clk_sys_i);
    {cs_v, cs_rd} <= {1'b1, rd};
    for (int k = 0; k < 70; k++)
    begin
      #1;
      for (int j = 0; j < 6; j++)
        if (pls[j] === 1'b1 && off[j] == 99)
          off[j] = k;
      @(posedge clk_sys_i);
      cs_v <= 1'b0;
    end
    for (int j = 0; j < 6; j++)
      check(32'(off[j]), 32'(exp[j]));
  endtask : cs_meas
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 12; i++)
    begin
      apb_xfer({16'h0, OFS[i]}, 1'b0, d, e);
      check(d, RST[i]);
      check(32'(e), 32'h0);
    end
    apb_xfer(32'h1258, 1'b1, d, e);
    check(d, 32'h0);
    check(32'(e), 32'h0);
    apb_xfer(32'h1258, 1'b0, d, e);
    check(d, RST_EP);
    apb_xfer(32'h1250, 1'b0, d, e);
    check(d, 32'h0);
    check(32'(e), 32'h1);
    apb_xfer(32'h00011258, 1'b0, d, e);
    check(d, 32'h0);
    check(32'(e), 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_update;
    logic [31:0] d;
    logic e;
    ctrl_state_t sl [3];
    sl = '{ST_CONFIG, ST_LOW_POWER, halted_state};
    st <= ST_READY;
    upd(OFS_EP, 32'h9);
    apb_xfer({16'h0, OFS_EP}, 1'b0, d, e);
    check(d, RST_EP);
    for (int i = 0; i < 3; i++)
    begin
      st <= sl[i];
      upd(OFS_EP, 32'(3 + i));
      apb_xfer({16'h0, OFS_EP}, 1'b0, d, e);
      check(d, 32'(3 + i));
      check(32'(act.pd_entry_cycles), 32'(3 + i));
    end
    measure(EV_PD_ENTRY, 2'h1, 0, 5);
    $display("test update done");
  endtask : t_update
  task automatic t_events;
    measure(EV_PD_EXIT, 2'h2, 1, 6);
    measure(EV_SR_ENTRY, 2'h2, 1, 14);
    measure(EV_SR_EXIT, 2'h2, 1, 1298);
    measure(EV_MPD_EXIT, 2'h2, 1, 1023);
    measure(EV_ZQ_SHORT, 2'h2, 1, 64);
    measure(EV_CLK_STOP, 2'h2, 2, 5);
    measure(EV_CLK_START, 2'h2, 2, 1);
    measure(EV_PD_EXIT, 2'h0, 0, 2);
    measure(EV_SR_EXIT, 2'h0, 0, 256);
    $display("test events done");
  endtask : t_events
  task automatic t_cs;
    logic [31:0] d;
    logic e;
    cs_meas(1'b1, '{0, 0, 9, 1, 0, 1});
    cs_meas(1'b0, '{0, 0, 9, 99, 99, 99});
    // Unbuffered parts, so a nonzero address latency is legal
    upd(OFS_CMD, 32'h00000203);
    // Completion of 12 covers the read deadline
    upd(OFS_PARITY, 32'h00000C02);
    upd(OFS_RDEN, 32'h00050704);
    upd(OFS_PHYRD, 32'h00000006);
    slow <= 1'b1;
    cs_meas(1'b1, '{3, 2, 12, 6, 5, 12});
    check(32'(late), 32'h0);
    apb_xfer({16'h0, OFS_RDEN}, 1'b0, d, e);
    check(d, 32'h00050704);
    $display("test chip select done");
  endtask : t_cs
  task automatic t_reset;
    logic [31:0] d;
    logic e;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb_xfer({16'h0, OFS_EP}, 1'b0, d, e);
    check(d, RST_EP);
    check(32'(dll), 32'hF);
    $display("test reset done");
  endtask : t_reset
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_regs;
    t_update;
    t_events;
    t_cs;
    t_reset;
    wrap_up;
  end
  initial
  begin
    #300000;
    error_cnt++;
    wrap_up;
  end
endmodule : testbench
bind timing_now timing_now_monitor #(.N_RANKS(N_RANKS)) timing_now_monitor_inst (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .ctrl_state_i(ctrl_state_i),
  .upd_valid_i(upd_valid_i), .evt_valid_i(evt_valid_i), .evt_kind_i(evt_kind_i), .evt_rank_i(evt_rank_i),
  .cs_valid_i(cs_valid_i), .cs_read_i(cs_read_i), .rank_nodll_ready_o(rank_nodll_ready_o),
  .rank_dll_ready_o(rank_dll_ready_o), .cmd_drive_o(cmd_drive_o), .cmd_done_o(cmd_done_o),
  .rd_en_o(rd_en_o), .rd_valid_deadline_o(rd_valid_deadline_o), .active_o(active_o));
`default_nettype wire
